/* shared/scan_tap_defines.svh */
`ifndef SCAN_TAP_DEFINES_SVH
`define SCAN_TAP_DEFINES_SVH

// register widths
`define IR_WIDTH        3
`define ID_WIDTH        32
`define BSR_WIDTH       73

// instruction codes
`define INSN_CAPTURE_Z  3'h0
`define INSN_IDENT      3'h1
`define INSN_SAMPLE_Z   3'h2
`define INSN_SAMPLE     3'h4
`define INSN_BYPASS     3'h7

// capture pattern for the two low instruction bits
`define IR_CAPTURE_PAT  2'h1

// identification word fields; maker and device values are arbitrary
`define ID_REVISION     3'h0
`define ID_DEVICE       16'hA5C3
`define ID_MAKER        12'h2D6
`define ID_PRESENT      1'h1

// mode-select high edges that always reach reset
`define RESET_EDGES     5

`endif

/* shared/scan_tap_pkg.sv */
package scan_tap_pkg;

  // sixteen states of the test port controller
  typedef enum logic [3:0] {
    TEST_RESET,
    RUN_IDLE,
    SEL_DR,
    CAP_DR,
    SHF_DR,
    EX1_DR,
    PAU_DR,
    EX2_DR,
    UPD_DR,
    SEL_IR,
    CAP_IR,
    SHF_IR,
    EX1_IR,
    PAU_IR,
    EX2_IR,
    UPD_IR
  } tap_state_e;

endpackage

/* rtl/scan_tap.sv */
// Overview of operation
// - inputs on rising, data out on falling edge; float follows the rise
// - mode-select steers states; undriven reads high
// - serial in at MSB, out at LSB
// - data out enabled only in shift states
// - five high mode-select edges reset controller
// - power-up reset leaves data out floating
// - exactly one register in serial path
// - three-bit instruction, identification after reset
// - capture-IR loads 01 into low bits
// - one-bit bypass, cleared on capture
// - boundary register covers all 73 pins
// - boundary captures ring, shifts in shift-DR
// - identification word captured then shifted out
// - new instruction takes effect at update-IR
// - all-zero code samples and floats outputs
// - float-sample code selects boundary, floats outputs
// - sample captures pins; update changes nothing
// - port never drives memory pins
// - bypass code puts bypass in path
// - reset and safe codes leave memory alone
// - decode codes 000,001,010,100,111
// - identification word layout, bit 0 one
`include "scan_tap_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module scan_tap
  import scan_tap_pkg::*;
(
  // system
  input  wire logic                  I_SYS_CLK,
  input  wire logic                  I_RESET_N,
  // test port pins
  input  wire logic                  I_TCK,
  input  wire logic                  I_TMS,
  input  wire logic                  I_TDI,
  output logic                       O_TDO,
  output logic                       O_TDO_OE,
  // memory side
  input  wire logic [`BSR_WIDTH-1:0] I_IO_RING,
  output logic                       O_MEM_OUT_FLOAT
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change counted when stages 2 and 3 agree
  // the test clock is sampled rather than used as a clock, so each of its
  // levels must last several system cycles or an edge is lost

  logic [2:0] tck_sync_q;  // test clock stages
  logic [2:0] tms_sync_q;  // mode-select stages
  logic [2:0] tdi_sync_q;  // serial in stages
  logic       tck_lvl_q;   // filtered test clock level
  logic       tms_lvl_q;   // filtered mode-select level
  logic       tdi_lvl_q;   // filtered serial in level
  logic [2:0] tck_sync_d;
  logic [2:0] tms_sync_d;
  logic [2:0] tdi_sync_d;
  logic       tck_lvl_d;
  logic       tms_lvl_d;
  logic       tdi_lvl_d;
  logic       tck_rise;    // one system cycle per rising test clock
  logic       tck_fall;    // one system cycle per falling test clock

  // next values of the synchronisers
  always_comb begin
    tck_sync_d = {tck_sync_q[1:0], I_TCK};
    tms_sync_d = {tms_sync_q[1:0], I_TMS};
    tdi_sync_d = {tdi_sync_q[1:0], I_TDI};
    tck_lvl_d  = tck_lvl_q;
    tms_lvl_d  = tms_lvl_q;
    tdi_lvl_d  = tdi_lvl_q;
    if (tck_sync_q[1] == tck_sync_q[2]) begin
      tck_lvl_d = tck_sync_q[2];
    end
    if (tms_sync_q[1] == tms_sync_q[2]) begin
      tms_lvl_d = tms_sync_q[2];
    end
    if (tdi_sync_q[1] == tdi_sync_q[2]) begin
      tdi_lvl_d = tdi_sync_q[2];
    end
  end

  // pulled-up pins reset high so a floating line reads as one
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tck_sync_q <= 3'h0;
      tms_sync_q <= 3'h7;
      tdi_sync_q <= 3'h7;
      tck_lvl_q  <= 1'h0;
      tms_lvl_q  <= 1'h1;
      tdi_lvl_q  <= 1'h1;
    end else begin
      tck_sync_q <= tck_sync_d;
      tms_sync_q <= tms_sync_d;
      tdi_sync_q <= tdi_sync_d;
      tck_lvl_q  <= tck_lvl_d;
      tms_lvl_q  <= tms_lvl_d;
      tdi_lvl_q  <= tdi_lvl_d;
    end
  end

  // edge detection on the filtered clock level
  // the pulse is combinational so the state moves on the same system
  // edge that registers the new filtered level
  assign tck_rise = tck_lvl_d & ~tck_lvl_q;
  assign tck_fall = ~tck_lvl_d & tck_lvl_q;

  //////////////////////////////////////////////////////////////////////////////
  // controller state machine

  tap_state_e state_q;  // current controller state
  tap_state_e state_d;

  // standard transitions; five high edges always land in reset
  // mode-select high from any state reaches reset within five rising
  // edges, so no separate counter is kept for it
  always_comb begin
    state_d = state_q;
    if (tck_rise) begin
      case (state_q)
        TEST_RESET: state_d = tms_lvl_q ? TEST_RESET : RUN_IDLE;
        RUN_IDLE:   state_d = tms_lvl_q ? SEL_DR : RUN_IDLE;
        SEL_DR:     state_d = tms_lvl_q ? SEL_IR : CAP_DR;
        CAP_DR:     state_d = tms_lvl_q ? EX1_DR : SHF_DR;
        SHF_DR:     state_d = tms_lvl_q ? EX1_DR : SHF_DR;
        EX1_DR:     state_d = tms_lvl_q ? UPD_DR : PAU_DR;
        PAU_DR:     state_d = tms_lvl_q ? EX2_DR : PAU_DR;
        EX2_DR:     state_d = tms_lvl_q ? UPD_DR : SHF_DR;
        UPD_DR:     state_d = tms_lvl_q ? SEL_DR : RUN_IDLE;
        SEL_IR:     state_d = tms_lvl_q ? TEST_RESET : CAP_IR;
        CAP_IR:     state_d = tms_lvl_q ? EX1_IR : SHF_IR;
        SHF_IR:     state_d = tms_lvl_q ? EX1_IR : SHF_IR;
        EX1_IR:     state_d = tms_lvl_q ? UPD_IR : PAU_IR;
        PAU_IR:     state_d = tms_lvl_q ? EX2_IR : PAU_IR;
        EX2_IR:     state_d = tms_lvl_q ? UPD_IR : SHF_IR;
        UPD_IR:     state_d = tms_lvl_q ? SEL_DR : RUN_IDLE;
        default:    state_d = TEST_RESET;
      endcase
    end
  end

  // power-up reset puts controller in its reset state
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q <= TEST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // scan registers

  localparam logic [`ID_WIDTH-1:0] ID_WORD = {`ID_REVISION, `ID_DEVICE, `ID_MAKER, `ID_PRESENT};

  logic [`IR_WIDTH-1:0]  ir_shift_q;  // instruction shift stage
  logic [`IR_WIDTH-1:0]  ir_q;        // active instruction
  logic                  byp_q;       // bypass bit
  logic [`ID_WIDTH-1:0]  id_q;        // identification shift register
  logic [`BSR_WIDTH-1:0] bsr_q;       // boundary register, capture only
  logic [`IR_WIDTH-1:0]  ir_shift_d;
  logic [`IR_WIDTH-1:0]  ir_d;
  logic                  byp_d;
  logic [`ID_WIDTH-1:0]  id_d;
  logic [`BSR_WIDTH-1:0] bsr_d;
  logic                  sel_bsr;     // boundary register selected
  logic                  sel_id;      // identification register selected

  // reserved codes fall to bypass; the controller should never load them
  // bypass is the shortest path, the safest place for a stray code
  always_comb begin
    sel_bsr = (ir_q == `INSN_CAPTURE_Z) || (ir_q == `INSN_SAMPLE_Z)
              || (ir_q == `INSN_SAMPLE);
    sel_id  = (ir_q == `INSN_IDENT);
  end

  // capture and shift; update-DR has no effect on any pin
  // the boundary register only captures; nothing it holds reaches a
  // memory pin, so the test port can never disturb the memory
  always_comb begin
    ir_shift_d = ir_shift_q;
    ir_d       = ir_q;
    byp_d      = byp_q;
    id_d       = id_q;
    bsr_d      = bsr_q;
    if (tck_rise) begin
      case (state_q)
        TEST_RESET: begin
          ir_d = `INSN_IDENT;
        end
        CAP_IR: begin
          ir_shift_d = {ir_q[`IR_WIDTH-1:2], `IR_CAPTURE_PAT};
        end
        SHF_IR: begin
          ir_shift_d = {tdi_lvl_q, ir_shift_q[`IR_WIDTH-1:1]};
        end
        UPD_IR: begin
          ir_d = ir_shift_q;
        end
        CAP_DR: begin
          if (sel_bsr) begin
            bsr_d = I_IO_RING;
          end else if (sel_id) begin
            id_d = ID_WORD;
          end else begin
            byp_d = 1'h0;
          end
        end
        SHF_DR: begin
          if (sel_bsr) begin
            bsr_d = {tdi_lvl_q, bsr_q[`BSR_WIDTH-1:1]};
          end else if (sel_id) begin
            id_d = {tdi_lvl_q, id_q[`ID_WIDTH-1:1]};
          end else begin
            byp_d = tdi_lvl_q;
          end
        end
        default: begin
          ir_d = ir_q;  // update-DR acts like a pause
        end
      endcase
    end
    // entering reset restores identification at once, so floats drop with it
    if (state_d == TEST_RESET) begin
      ir_d = `INSN_IDENT;
    end
  end

  // instruction resets to identification at power-up
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ir_shift_q <= `INSN_IDENT;
      ir_q       <= `INSN_IDENT;
      byp_q      <= 1'h0;
      id_q       <= '0;
      bsr_q      <= '0;
    end else begin
      ir_shift_q <= ir_shift_d;
      ir_q       <= ir_d;
      byp_q      <= byp_d;
      id_q       <= id_d;
      bsr_q      <= bsr_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial output, launched on falling test clock

  logic tdo_q;     // serial out value
  logic tdo_oe_q;  // serial out driver enable
  logic float_q;   // memory output float
  logic tdo_d;
  logic tdo_oe_d;
  logic float_d;

  // one register reaches the pin, chosen by state and instruction
  // the enable follows the state entered at the last rise, so it turns
  // on half a test clock into a shift state and off half a clock after
  always_comb begin
    tdo_d    = tdo_q;
    tdo_oe_d = tdo_oe_q;
    if (tck_fall) begin
      tdo_oe_d = (state_q == SHF_DR) || (state_q == SHF_IR);
      if (state_q == SHF_IR) begin
        tdo_d = ir_shift_q[0];
      end else if (sel_bsr) begin
        tdo_d = bsr_q[0];
      end else if (sel_id) begin
        tdo_d = id_q[0];
      end else begin
        tdo_d = byp_q;
      end
    end
    // float is a registered level one system cycle behind the
    // instruction, so the memory side never sees a decode glitch
    // float only for the two floating codes; memory never driven otherwise
    float_d = (ir_q == `INSN_CAPTURE_Z) || (ir_q == `INSN_SAMPLE_Z);
  end

  // driver off at power-up
  // data out resets low but stays undriven since its enable resets low
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tdo_q    <= 1'h0;
      tdo_oe_q <= 1'h0;
      float_q  <= 1'h0;
    end else begin
      tdo_q    <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
      float_q  <= float_d;
    end
  end

  // no path to memory address, control or data exists
  assign O_TDO           = tdo_q;
  assign O_TDO_OE        = tdo_oe_q;
  assign O_MEM_OUT_FLOAT = float_q;

endmodule

`default_nettype wire

/* testbench/scan_tap_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// pin-level watch of the test port, seen from the system clock
module scan_tap_asserts (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  // pins
  input wire logic I_TCK,
  input wire logic I_TMS,
  input wire logic O_TDO,
  input wire logic O_TDO_OE,
  input wire logic O_MEM_OUT_FLOAT
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  logic [3:0] fall_q; // cycles since pin clock fell
  logic [3:0] rise_q; // cycles since pin clock rose
  logic [2:0] high_q; // rises in a row with mode high
  logic       tms_q;  // mode level at last rise
  ////////////////////////////////////////
  // timers saturate so long idles stay quiet
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      fall_q <= 4'hF;
      rise_q <= 4'hF;
      high_q <= 3'h0;
      tms_q  <= 1'b1;
    end else begin
      fall_q <= $fell(I_TCK) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hF};
      rise_q <= $rose(I_TCK) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hF};
      if ($rose(I_TCK)) begin
        tms_q  <= I_TMS;
        high_q <= I_TMS ? high_q + {2'h0, high_q != 3'h5} : 3'h0;
      end
    end
  end
  ////////////////////////////////////////
  chk_tdo_on_fall: assert property ($changed(O_TDO) |-> fall_q inside {[2:7]})
    else $error("data out moved away from a falling clock");
  chk_oe_on_fall: assert property ($changed(O_TDO_OE) |-> fall_q inside {[2:7]})
    else $error("enable moved away from a falling clock");
  chk_float_on_rise: assert property ($changed(O_MEM_OUT_FLOAT) |-> rise_q inside {[2:8]})
    else $error("float moved away from a rising clock");
  chk_oe_rise_shift: assert property ($rose(O_TDO_OE) |-> !tms_q)
    else $error("enable rose without mode low");
  chk_oe_fall_exit: assert property ($fell(O_TDO_OE) |-> tms_q)
    else $error("enable fell without mode high");
  chk_power_oe_off: assert property ($rose(I_RESET_N) |-> !O_TDO_OE [*8])
    else $error("enable high after power-up");
  chk_power_float_off: assert property ($rose(I_RESET_N) |-> !O_MEM_OUT_FLOAT [*8])
    else $error("float high after power-up");
  chk_mode_reset: assert property (high_q == 3'h5 |-> ##8 !O_MEM_OUT_FLOAT && !O_TDO_OE)
    else $error("five mode-high rises left port active");
endmodule
`default_nettype wire

/* testbench/scan_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// board test controller driving the pin clock, mode and data
module scan_ctrl_model (
  input  wire logic clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // idle: clock parked low, mode and data at pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  ////////////////////////////////////////
  // one pin clock; reply read late in high phase since it lags the fall
  task automatic pulse(input logic m, input logic d, output logic o, output logic e);
    repeat (2) @(negedge clk);
    tms = m;
    tdi = d;
    repeat (2) @(negedge clk);
    tck = 1'b1;
    repeat (4) @(negedge clk);
    o = tdo_oe ? tdo : ~tdo; // undriven line never shows a good bit
    e = tdo_oe;
    tck = 1'b0;
    tdi = 1'b1;
  endtask
  // five rises with mode high
  task automatic reset5;
    logic o;
    logic e;
    repeat (5) pulse(1'b1, 1'b1, o, e);
  endtask
endmodule
`default_nettype wire

/* testbench/scan_tap_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scan_tap_defines.svh"
`define CHK(nm, ex, got) begin \
  checked++; \
  if ((got) !== (ex)) begin \
    n_errors++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module scan_tap_tb;
  logic                  clk;
  logic                  rst_n;
  logic                  tck, tms, tdi, tdo, oe, flt, o, e;
  logic [`BSR_WIDTH-1:0] ring;     // pin ring seen by the port
  int                    n_errors = 0;
  int                    checked = 0;
  int                    ir_m;     // model of live instruction
  int                    codes[6] = '{0, 2, 4, 7, 7, 1};
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  scan_tap scan_tap_inst (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
    .O_TDO(tdo), .O_TDO_OE(oe), .I_IO_RING(ring), .O_MEM_OUT_FLOAT(flt));
  scan_ctrl_model scan_ctrl_model_inst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(oe));
  ////////////////////////////////////////
  // from idle through select, shift n bits, back to idle
  task automatic scan(input bit ir, input int n, input logic [79:0] din, output logic [79:0] dout);
    logic all_e;
    all_e = 1'b1;
    dout = '0;
    scan_ctrl_model_inst.pulse(1'b1, 1'b1, o, e);
    if (ir) scan_ctrl_model_inst.pulse(1'b1, 1'b1, o, e);
    scan_ctrl_model_inst.pulse(1'b0, 1'b1, o, e);
    scan_ctrl_model_inst.pulse(1'b0, 1'b1, o, e);
    for (int i = 0; i < n; i++) begin
      scan_ctrl_model_inst.pulse(i == n - 1, din[i], o, e);
      dout[i] = o;
      all_e &= e;
    end
    scan_ctrl_model_inst.pulse(1'b1, 1'b1, o, e);
    scan_ctrl_model_inst.pulse(1'b0, 1'b1, o, e);
    `CHK("oe in shift", 1'b1, all_e)
    `CHK("oe idle", 1'b0, oe)
  endtask
  // data scan: captured word LSB first, then input delayed by length
  task automatic dr_check;
    logic [79:0] din, dout, cap, mask;
    int w;
    ring = 73'({$urandom, $urandom, $urandom});
    din = 80'({$urandom, $urandom, $urandom});
    w = (ir_m == 1) ? 32 : (ir_m == 7) ? 1 : 73;
    cap = (ir_m == 1) ? 80'({`ID_REVISION, `ID_DEVICE, `ID_MAKER, `ID_PRESENT}) : (ir_m == 7) ? '0 : 80'(ring);
    mask = (80'h1 << (w + 4)) - 80'h1;
    scan(1'b0, w + 4, din, dout);
    `CHK("data path", ((din << w) | cap) & mask, dout)
    `CHK("float kept", 1'(ir_m == 0 || ir_m == 2), flt)
  endtask
  // instruction scan then update
  task automatic load_ir(input int code);
    logic [79:0] dout;
    scan(1'b1, 3, 80'(code), dout);
    `CHK("ir capture", 80'({ir_m[2], 2'b01}), dout)
    ir_m = code;
    repeat (2) @(negedge clk); // float lags the update rise by five cycles
    `CHK("float", 1'(code == 0 || code == 2), flt)
  endtask
  task automatic conclude;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ring = '0;
    ir_m = 1;
    void'($urandom(40));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    `CHK("oe power-up", 1'b0, oe)
    repeat (4) @(negedge clk);
    scan_ctrl_model_inst.pulse(1'b0, 1'b1, o, e);
    dr_check();
    foreach (codes[k]) begin
      load_ir(codes[k]);
      dr_check();
      dr_check();
    end
    load_ir(2);
    scan_ctrl_model_inst.reset5();
    scan_ctrl_model_inst.pulse(1'b0, 1'b1, o, e);
    ir_m = 1;
    `CHK("float after reset", 1'b0, flt)
    dr_check();
    load_ir(2);
    rst_n = 1'b0; // power-up reset again in mid-run
    repeat (3) @(negedge clk);
    `CHK("float in reset", 1'b0, flt)
    `CHK("oe in reset", 1'b0, oe)
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    scan_ctrl_model_inst.pulse(1'b0, 1'b1, o, e);
    ir_m = 1;
    dr_check();
    conclude();
  end
endmodule
bind scan_tap scan_tap_asserts scan_tap_asserts_inst (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N),
  .I_TCK(I_TCK), .I_TMS(I_TMS), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE), .O_MEM_OUT_FLOAT(O_MEM_OUT_FLOAT));
`default_nettype wire
